// ===== sfbr_pkg.sv
// shared constants for the serial flags and rate divisor block
package sfbr_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_RATE_DIV0  = 16'hFED9;
    localparam logic [15:0] IDX_FLAGS0     = 16'hFEDC;
    localparam logic [15:0] IDX_RATE_DIV1  = 16'hFEF1;
    localparam logic [15:0] IDX_FLAGS1     = 16'hFEF4;
    localparam logic [15:0] IDX_CTRL0      = 16'hFF00;
    localparam logic [15:0] IDX_CTRL1      = 16'hFF01;
    localparam int          ADDR_W         = 18;
    localparam int          NUM_CH         = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  FLAGS_RESET    = 8'h87;
    localparam logic [7:0]  RATE_RESET     = 8'hFF;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [2:0]  FLAGS_LOW_ONES = 3'h7;

    // ------------------------------------------------------------
    // field positions: flags word bits 7..3 map to flag vector 4..0
    // ------------------------------------------------------------
    localparam int F_TX_EMPTY = 4;
    localparam int F_RX_FULL  = 3;
    localparam int F_OVERRUN  = 2;
    localparam int F_FRAMING  = 1;
    localparam int F_PARITY   = 0;
    // control register fields
    localparam int C_TX_IRQ_EN = 7;
    localparam int C_RX_IRQ_EN = 6;
    localparam int C_TX_ON     = 5;
    localparam int C_SYNC      = 4;
    localparam int C_PAR_EN    = 3;
    localparam int C_PAR_ODD   = 2;
    localparam int C_PRESC_HI  = 1;
    localparam int C_PRESC_LO  = 0;

    // ------------------------------------------------------------
    // timing: one async bit spans one more than this many generator ticks
    // ------------------------------------------------------------
    localparam logic [5:0]  BIT_TICKS_M1   = 6'h3F;

    // prescaler terminal count for code n: 4**n - 1 (0, 3, 15, 63)
    function automatic logic [5:0] sfbr_presc_last(input logic [1:0] code);
        case (code)
            2'h0:    sfbr_presc_last = 6'h00;
            2'h1:    sfbr_presc_last = 6'h03;
            2'h2:    sfbr_presc_last = 6'h0F;
            default: sfbr_presc_last = 6'h3F;
        endcase
    endfunction : sfbr_presc_last
endpackage : sfbr_pkg

// ===== sfbr_flag_if.sv
// software access strobes and flag state passed between top and flag logic
`timescale 1ns/1ns
interface sfbr_flag_if;
    logic       rdStrobe;   // completed software read of the flags word
    logic [4:0] rdSeen;     // flag values that read returned
    logic       wrStrobe;   // completed software write of the flags word
    logic [4:0] wrData;     // written flag bits
    logic [4:0] flags;      // current flag state
    modport bus   (output rdStrobe, output rdSeen, output wrStrobe, output wrData, input flags);
    modport keeper (input rdStrobe, input rdSeen, input wrStrobe, input wrData, output flags);
endinterface : sfbr_flag_if

// ===== sfbr_flags.sv
// status flags of one channel with read-then-write-zero clearing
`timescale 1ns/1ns
module sfbr_flags
    import sfbr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       standby,
    input  wire logic [7:0] ctrl,
    input  wire logic       txShiftLoad,
    input  wire logic       dtcWriteTx,
    input  wire logic       dtcReadRx,
    input  wire logic       rxDone,
    input  wire logic       rxStopBit,
    input  wire logic       rxParityBit,
    input  wire logic [7:0] rxData,
    sfbr_flag_if.keeper     sw
);
    logic [4:0] flags_r, flags_nxt;
    logic [4:0] armed_r, armed_nxt;
    logic [4:0] setEv, clrEv;
    logic       parBad;

    // ------------------------------------------------------------
    // next state: set events win over any clear in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        parBad = ((^rxData) ^ rxParityBit) != ctrl[C_PAR_ODD];
        setEv  = 5'h00;
        clrEv  = 5'h00;
        setEv[F_TX_EMPTY] = txShiftLoad
                          | (~flags_r[F_TX_EMPTY] & ~ctrl[C_TX_ON]);
        // a completion while still full is an overrun and the new char is dropped
        setEv[F_OVERRUN]  = rxDone & flags_r[F_RX_FULL];
        setEv[F_FRAMING]  = rxDone & ~flags_r[F_RX_FULL] & ~rxStopBit;
        // only meaningful in async mode with parity on, never raised otherwise
        setEv[F_PARITY]   = rxDone & ~flags_r[F_RX_FULL] & ~ctrl[C_SYNC]
                          & ctrl[C_PAR_EN] & parBad;
        setEv[F_RX_FULL]  = rxDone & ~flags_r[F_RX_FULL] & rxStopBit
                          & ~setEv[F_PARITY];
        if (sw.wrStrobe) begin
            clrEv = armed_r & ~sw.wrData;
        end
        clrEv[F_TX_EMPTY] = clrEv[F_TX_EMPTY] | dtcWriteTx;
        clrEv[F_RX_FULL]  = clrEv[F_RX_FULL] | dtcReadRx;
        flags_nxt = (flags_r & ~clrEv) | setEv;
        // a flag is armed once read as 1; any write to the word disarms it
        armed_nxt = armed_r | (sw.rdStrobe ? sw.rdSeen : 5'h00);
        if (sw.wrStrobe) begin
            armed_nxt = 5'h00;
        end
        armed_nxt = armed_nxt & flags_nxt;
        if (standby) begin
            flags_nxt = FLAGS_RESET[7:3];
            armed_nxt = 5'h00;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_r <= FLAGS_RESET[7:3];
            armed_r <= 5'h00;
        end else begin
            flags_r <= flags_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign sw.flags = flags_r;
endmodule : sfbr_flags

// ===== sfbr_baud.sv
// rate generator: prescaler then divisor counter, with bit tick
`timescale 1ns/1ns
module sfbr_baud
    import sfbr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       standby,
    input  wire logic [1:0] prescSel,
    input  wire logic [7:0] divisor,
    output logic            baudTick,
    output logic            bitTick
);
    logic [5:0] presc_r, presc_nxt;
    logic [7:0] div_r, div_nxt;
    logic [5:0] bit_r, bit_nxt;
    logic       baud_r, baud_nxt, bitT_r, bitT_nxt;
    logic       prescEnd;

    // ------------------------------------------------------------
    // tick every 4**n * (N+1) clocks; bit tick every 64 of those
    // ------------------------------------------------------------
    always_comb begin
        prescEnd  = presc_r >= sfbr_presc_last(prescSel);
        presc_nxt = prescEnd ? 6'h00 : presc_r + 6'h01;
        div_nxt   = div_r;
        bit_nxt   = bit_r;
        baud_nxt  = 1'b0;
        bitT_nxt  = 1'b0;
        if (prescEnd) begin
            // >= so a divisor lowered mid-count cannot strand the counter
            if (div_r >= divisor) begin
                div_nxt  = 8'h00;
                baud_nxt = 1'b1;
                bit_nxt  = bit_r + 6'h01;
                bitT_nxt = bit_r == BIT_TICKS_M1;
            end else begin
                div_nxt = div_r + 8'h01;
            end
        end
        if (standby) begin
            presc_nxt = 6'h00;
            div_nxt   = 8'h00;
            bit_nxt   = 6'h00;
            baud_nxt  = 1'b0;
            bitT_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presc_r <= 6'h00;
            div_r   <= 8'h00;
            bit_r   <= 6'h00;
            baud_r  <= 1'b0;
            bitT_r  <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            div_r   <= div_nxt;
            bit_r   <= bit_nxt;
            baud_r  <= baud_nxt;
            bitT_r  <= bitT_nxt;
        end
    end

    assign baudTick = baud_r;
    assign bitTick  = bitT_r;
endmodule : sfbr_baud

// ===== sfbr_top.sv
// two-channel serial flags, rate divisors and apb slave
`timescale 1ns/1ns
module sfbr_top
    import sfbr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              standby,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic [1:0]        txShiftLoad,
    input  wire logic [1:0]        dtcWriteTx,
    input  wire logic [1:0]        dtcReadRx,
    input  wire logic [1:0]        rxDone,
    input  wire logic [1:0]        rxStopBit,
    input  wire logic [1:0]        rxParityBit,
    input  wire logic [15:0]       rxData,
    output logic [1:0]             txOn,
    output logic [1:0]             baudTick,
    output logic [1:0]             bitTick,
    output logic [1:0]             txEmptyIrq,
    output logic [1:0]             rxFullIrq,
    output logic [1:0]             rxErrorIrq
);
    sfbr_flag_if flagIf [NUM_CH] ();

    logic [7:0]  rate_r [NUM_CH];
    logic [7:0]  rate_nxt [NUM_CH];
    logic [7:0]  ctrl_r [NUM_CH];
    logic [7:0]  ctrl_nxt [NUM_CH];
    logic [4:0]  flagsNow [NUM_CH];
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [1:0]  txIrq_r, txIrq_nxt;
    logic [1:0]  rxIrq_r, rxIrq_nxt;
    logic [1:0]  errIrq_r, errIrq_nxt;
    logic [1:0]  txOn_r, txOn_nxt;
    logic [15:0] wordIdx;
    logic        setupPh, doneWr, doneRd;
    logic [1:0]  selFlags, selRate, selCtrl;

    // ------------------------------------------------------------
    // address decode: word index is the byte address over four
    // ------------------------------------------------------------
    assign wordIdx  = paddr[ADDR_W-1:2];
    assign setupPh  = psel & ~penable;
    // a transfer completes at the edge where pready is sampled high
    assign doneWr   = psel & penable & pready_r & pwrite;
    assign doneRd   = psel & penable & pready_r & ~pwrite;
    assign selFlags = {wordIdx == IDX_FLAGS1,    wordIdx == IDX_FLAGS0};
    assign selRate  = {wordIdx == IDX_RATE_DIV1, wordIdx == IDX_RATE_DIV0};
    assign selCtrl  = {wordIdx == IDX_CTRL1,     wordIdx == IDX_CTRL0};

    // ------------------------------------------------------------
    // per-channel flag logic and rate generator
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        // only byte lane 0 carries the 8-bit registers
        assign flagIf[c].wrStrobe = doneWr & selFlags[c] & pstrb[0];
        assign flagIf[c].wrData   = pwdata[7:3];
        assign flagIf[c].rdStrobe = doneRd & selFlags[c] & ~pslverr_r;
        assign flagIf[c].rdSeen   = prdata_r[7:3];
        assign flagsNow[c]        = flagIf[c].flags;

        sfbr_flags u_flags (
            .clk_sys     (clk_sys),
            .rst         (rst),
            .standby     (standby),
            .ctrl        (ctrl_r[c]),
            .txShiftLoad (txShiftLoad[c]),
            .dtcWriteTx  (dtcWriteTx[c]),
            .dtcReadRx   (dtcReadRx[c]),
            .rxDone      (rxDone[c]),
            .rxStopBit   (rxStopBit[c]),
            .rxParityBit (rxParityBit[c]),
            .rxData      (rxData[c*8 +: 8]),
            .sw          (flagIf[c])
        );

        sfbr_baud u_baud (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .standby  (standby),
            .prescSel ({ctrl_r[c][C_PRESC_HI], ctrl_r[c][C_PRESC_LO]}),
            .divisor  (rate_r[c]),
            .baudTick (baudTick[c]),
            .bitTick  (bitTick[c])
        );
    end

    // ------------------------------------------------------------
    // register writes and interrupt levels
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            rate_nxt[c] = rate_r[c];
            ctrl_nxt[c] = ctrl_r[c];
            if (doneWr & pstrb[0] & selRate[c]) begin
                rate_nxt[c] = pwdata[7:0];
            end
            if (doneWr & pstrb[0] & selCtrl[c]) begin
                ctrl_nxt[c] = pwdata[7:0];
            end
            if (standby) begin
                rate_nxt[c] = RATE_RESET;
                ctrl_nxt[c] = CTRL_RESET;
            end
            // levels follow the flags one clock later, like all outputs
            txIrq_nxt[c]  = flagsNow[c][F_TX_EMPTY] & ctrl_r[c][C_TX_IRQ_EN];
            rxIrq_nxt[c]  = flagsNow[c][F_RX_FULL] & ctrl_r[c][C_RX_IRQ_EN];
            errIrq_nxt[c] = ctrl_r[c][C_RX_IRQ_EN]
                          & (flagsNow[c][F_OVERRUN] | flagsNow[c][F_FRAMING]
                          |  flagsNow[c][F_PARITY]);
            txOn_nxt[c]   = ctrl_r[c][C_TX_ON];
        end
    end

    // ------------------------------------------------------------
    // apb answer: data captured in setup, ready in access phase
    // ------------------------------------------------------------
    always_comb begin
        pready_nxt  = setupPh;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata_r;
        if (setupPh) begin
            prdata_nxt  = 32'h0000_0000;
            pslverr_nxt = ~(|selFlags | |selRate | |selCtrl);
            for (int c = 0; c < NUM_CH; c++) begin
                if (selFlags[c]) begin
                    prdata_nxt[7:0] = {flagsNow[c], FLAGS_LOW_ONES};
                end
                if (selRate[c]) begin
                    prdata_nxt[7:0] = rate_r[c];
                end
                if (selCtrl[c]) begin
                    prdata_nxt[7:0] = ctrl_r[c];
                end
            end
        end
        // error stands only beside pready, never in the idle cycle after it
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                rate_r[c] <= RATE_RESET;
                ctrl_r[c] <= CTRL_RESET;
            end
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            txIrq_r   <= 2'h0;
            rxIrq_r   <= 2'h0;
            errIrq_r  <= 2'h0;
            txOn_r    <= 2'h0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                rate_r[c] <= rate_nxt[c];
                ctrl_r[c] <= ctrl_nxt[c];
            end
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            txIrq_r   <= txIrq_nxt;
            rxIrq_r   <= rxIrq_nxt;
            errIrq_r  <= errIrq_nxt;
            txOn_r    <= txOn_nxt;
        end
    end

    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign prdata     = prdata_r;
    assign txEmptyIrq = txIrq_r;
    assign rxFullIrq  = rxIrq_r;
    assign rxErrorIrq = errIrq_r;
    assign txOn       = txOn_r;
endmodule : sfbr_top

// ===== sfbr_checker.sv
// concurrent checks on the ports of the serial flags and rate divisor block
`timescale 1ns/1ns
module sfbr_checker
    import sfbr_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              standby,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic [1:0]        rxDone,
    input wire logic [1:0]        dtcReadRx,
    input wire logic [1:0]        bitTick,
    input wire logic [1:0]        rxFullIrq,
    input wire logic [1:0]        rxErrorIrq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       acc;
    logic [7:0] gapCnt_r;
    logic [7:0] gapCnt_nxt;
    assign acc = psel & penable & pwrite;
    // clocks since the last bit tick; saturates so a long gap never wraps
    always_comb begin
        gapCnt_nxt = (gapCnt_r == 8'hFF) ? gapCnt_r : gapCnt_r + 8'h01;
        if (bitTick[0]) gapCnt_nxt = 8'h00;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) gapCnt_r <= 8'h00;
        else gapCnt_r <= gapCnt_nxt;
    end
    // ------------------------------------------------------------
    // bus and register checks
    // ------------------------------------------------------------
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    a_ready_after_setup: assert property (pready |-> $past(psel && !penable))
        else $error("pready without a preceding setup cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside an access phase");
    a_upper_data_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above the byte lane not zero");
    a_reserved_ones: assert property (
        pready && !pwrite && !pslverr && (paddr[17:2] == IDX_FLAGS0 || paddr[17:2] == IDX_FLAGS1)
        |-> prdata[2:0] == FLAGS_LOW_ONES) else $error("flags low bits not read as ones");
    // bit ticks need 64 generator ticks of at least one clock each
    a_bit_spacing: assert property (bitTick[0] |-> gapCnt_r >= 8'h3F)
        else $error("bit ticks closer than 64 clocks");
    // ------------------------------------------------------------
    // interrupt causes: only a reception, a receive-data read, a register write or a reset hold
    // ------------------------------------------------------------
    a_err_irq_cause: assert property ($rose(rxErrorIrq[1]) |->
        $past(rxDone[1]) || $past(rxDone[1], 2) || $past(acc) || $past(acc, 2) || $past(acc, 3))
        else $error("error interrupt rose without a cause");
    a_err_irq_clear: assert property ($fell(rxErrorIrq[1]) |->
        $past(acc) || $past(acc, 2) || $past(acc, 3) || $past(standby) || $past(standby, 2))
        else $error("error interrupt fell without a clear");
    a_full_irq_cause: assert property ($rose(rxFullIrq[1]) |->
        $past(rxDone[1]) || $past(rxDone[1], 2) || $past(acc) || $past(acc, 2) || $past(acc, 3))
        else $error("receive interrupt rose without a cause");
    a_full_irq_clear: assert property ($fell(rxFullIrq[1]) |->
        $past(dtcReadRx[1]) || $past(dtcReadRx[1], 2) || $past(acc) || $past(acc, 2) || $past(acc, 3)
        || $past(standby) || $past(standby, 2)) else $error("receive interrupt fell without a clear");
endmodule : sfbr_checker

bind sfbr_top sfbr_checker u_chk (.clk_sys(clk_sys), .rst(rst), .standby(standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rxDone(rxDone), .dtcReadRx(dtcReadRx), .bitTick(bitTick),
    .rxFullIrq(rxFullIrq), .rxErrorIrq(rxErrorIrq));

// ===== test_serial_status_and_baud_setting.sv
// self-checking bench for the serial flags and rate divisor block
`timescale 1ns/1ns
module test_serial_status_and_baud_setting;
    import sfbr_pkg::*;
    logic              clk_sys = 1'h0;
    logic              rst = 1'h1;
    logic              standby = 1'h0;
    logic              psel = 1'h0;
    logic              penable = 1'h0;
    logic              pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = 32'h0;
    logic [3:0]        pstrb = 4'hF;
    logic [1:0]        txShiftLoad = 2'h0, dtcWriteTx = 2'h0, dtcReadRx = 2'h0;
    logic [1:0]        rxDone = 2'h0, rxStopBit = 2'h0, rxParityBit = 2'h0;
    logic [15:0]       rxData = 16'h0;
    logic [31:0]       prdata, rd;
    logic              pready, pslverr, err;
    logic [1:0]        txOn, baudTick, bitTick, txEmptyIrq, rxFullIrq, rxErrorIrq;
    int                n_fail = 0, comparisons = 0, cycles = 0, n;

    sfbr_top dut (.clk_sys(clk_sys), .rst(rst), .standby(standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .txShiftLoad(txShiftLoad), .dtcWriteTx(dtcWriteTx),
        .dtcReadRx(dtcReadRx), .rxDone(rxDone), .rxStopBit(rxStopBit), .rxParityBit(rxParityBit),
        .rxData(rxData), .txOn(txOn), .baudTick(baudTick), .bitTick(bitTick),
        .txEmptyIrq(txEmptyIrq), .rxFullIrq(rxFullIrq), .rxErrorIrq(rxErrorIrq));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard: the whole run needs well under this many clocks
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb
    // one apb transfer; waits for pready rather than assuming zero waits
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int w;
        w = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (pready !== 1'h1 && w < 16) begin
            @(posedge clk_sys);
            w++;
        end
        if (w == 16) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask : rdc
    // one-cycle strobe: k = {rxDone, dtcReadRx, dtcWriteTx, txShiftLoad}
    task automatic hw(input int ch, input logic [3:0] k, input logic stop, input logic [7:0] d);
        @(posedge clk_sys);
        txShiftLoad[ch] <= k[0];
        dtcWriteTx[ch] <= k[1];
        dtcReadRx[ch] <= k[2];
        rxDone[ch] <= k[3];
        rxStopBit[ch] <= stop;
        rxData[ch*8 +: 8] <= d;
        @(posedge clk_sys);
        {txShiftLoad, dtcWriteTx, dtcReadRx, rxDone} <= 8'h00;
        rxStopBit[ch] <= ~stop;
        rxData[ch*8 +: 8] <= ~d;
        repeat (2) @(posedge clk_sys);
    endtask : hw
    // clocks between two ticks of channel 0; b selects bit tick
    task automatic gap(input logic b);
        int w;
        w = 0;
        @(posedge clk_sys);
        while ((b ? bitTick[0] : baudTick[0]) !== 1'h1 && w < 9000) begin
            @(posedge clk_sys);
            w++;
        end
        @(posedge clk_sys);
        n = 1;
        while ((b ? bitTick[0] : baudTick[0]) !== 1'h1 && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : gap
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdc(IDX_FLAGS0, 8'h87);
        rdc(IDX_FLAGS1, 8'h87);
        rdc(IDX_RATE_DIV0, 8'hFF);
        rdc(IDX_RATE_DIV1, 8'hFF);
        apb(1'h1, IDX_RATE_DIV1, 8'hA5);
        rdc(IDX_RATE_DIV1, 8'hA5);
        pstrb <= 4'h0;
        apb(1'h1, IDX_RATE_DIV1, 8'h11);
        pstrb <= 4'hF;
        rdc(IDX_RATE_DIV1, 8'hA5);
        apb(1'h0, 16'h0010, 8'h00);
        chkb(err, 1'h1);
        apb(1'h1, IDX_FLAGS1, 8'h80);
        rdc(IDX_FLAGS1, 8'h87);
    endtask : t_regs
    task automatic t_tx();
        apb(1'h1, IDX_CTRL0, 8'hA0);
        rdc(IDX_FLAGS0, 8'h87);
        hw(0, 4'h2, 1'h1, 8'h00);
        rdc(IDX_FLAGS0, 8'h07);
        chkb(txEmptyIrq[0], 1'h0);
        hw(0, 4'h1, 1'h1, 8'h00);
        apb(1'h1, IDX_FLAGS0, 8'h7F);
        rdc(IDX_FLAGS0, 8'h87);
        chkb(txEmptyIrq[0], 1'h1);
        apb(1'h1, IDX_FLAGS0, 8'hFF);
        apb(1'h1, IDX_FLAGS0, 8'h7F);
        rdc(IDX_FLAGS0, 8'h87);
        apb(1'h1, IDX_FLAGS0, 8'h7F);
        rdc(IDX_FLAGS0, 8'h07);
        apb(1'h1, IDX_CTRL0, 8'h80);
        rdc(IDX_FLAGS0, 8'h87);
        chkb(txOn[0], 1'h0);
    endtask : t_tx
    task automatic t_rx();
        apb(1'h1, IDX_CTRL1, 8'h40);
        hw(1, 4'h8, 1'h1, 8'h3C);
        rdc(IDX_FLAGS1, 8'hC7);
        chkb(rxFullIrq[1], 1'h1);
        hw(1, 4'h8, 1'h1, 8'h3C);
        rdc(IDX_FLAGS1, 8'hE7);
        chkb(rxErrorIrq[1], 1'h1);
        hw(1, 4'h4, 1'h1, 8'h00);
        rdc(IDX_FLAGS1, 8'hA7);
        apb(1'h1, IDX_FLAGS1, 8'h00);
        rdc(IDX_FLAGS1, 8'h87);
        chkb(rxErrorIrq[1], 1'h0);
        hw(1, 4'h8, 1'h0, 8'h3C);
        rdc(IDX_FLAGS1, 8'h97);
        apb(1'h1, IDX_CTRL1, 8'h48);
        hw(1, 4'h8, 1'h1, 8'h01);
        rdc(IDX_FLAGS1, 8'h9F);
        apb(1'h1, IDX_FLAGS1, 8'h00);
        apb(1'h1, IDX_CTRL1, 8'h58);
        hw(1, 4'h8, 1'h1, 8'h01);
        rdc(IDX_FLAGS1, 8'hC7);
        apb(1'h1, IDX_FLAGS1, 8'h00);
        apb(1'h1, IDX_CTRL1, 8'h4C);
        hw(1, 4'h8, 1'h1, 8'h01);
        rdc(IDX_FLAGS1, 8'hC7);
        @(posedge clk_sys);
        standby <= 1'h1;
        repeat (2) @(posedge clk_sys);
        standby <= 1'h0;
        rdc(IDX_FLAGS1, 8'h87);
        rdc(IDX_RATE_DIV1, 8'hFF);
        chkb(rxFullIrq[1], 1'h0);
    endtask : t_rx
    task automatic t_baud();
        apb(1'h1, IDX_RATE_DIV0, 8'h01);
        for (int c = 0; c < 4; c++) begin
            apb(1'h1, IDX_CTRL0, 8'(c));
            gap(1'h0);
            gap(1'h0);
            chk(n, 2 << (2 * c));
        end
        apb(1'h1, IDX_CTRL0, 8'h00);
        gap(1'h1);
        gap(1'h1);
        chk(n, 128);
    endtask : t_baud

    task automatic print_verdict();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        t_regs();
        t_tx();
        t_rx();
        t_baud();
        print_verdict();
    end
endmodule : test_serial_status_and_baud_setting
